/* pfs_pkg.sv */
// Shared constants, types and helpers of the program flash self-access controller
package pfs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_KHZ = 10000;
	localparam int unsigned ERASE_TIME_MS = 4;
	localparam int unsigned ERASE_CYCLES = ERASE_TIME_MS * CLK_KHZ;
	localparam logic [15:0] SETUP_LAST = 16'h0001;

	// ----------------------------------------
	// Register map (word index on the register port)
	// ----------------------------------------
	localparam logic [2:0] REG_ADDR_LOW = 3'h0;
	localparam logic [2:0] REG_ADDR_HIGH = 3'h1;
	localparam logic [2:0] REG_DATA_LOW = 3'h2;
	localparam logic [2:0] REG_DATA_HIGH = 3'h3;
	localparam logic [2:0] REG_ACCESS_CONTROL = 3'h4;
	localparam logic [2:0] REG_UNLOCK = 3'h5;
	localparam logic [2:0] REG_PROTECT_CFG = 3'h6;

	// Control register fields
	localparam int CTL_SELECT_BIT = 7;
	localparam int CTL_WEN_BIT = 2;
	localparam int CTL_WR_BIT = 1;
	localparam int CTL_RD_BIT = 0;

	// Reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [1:0] PROTECT_RESET = 2'h3;

	// Unlock keys and block geometry
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
	localparam logic [2:0] BLOCK_LAST_WORD = 3'h7;

	// Protection limits: addresses below the limit are locked
	localparam logic [12:0] PROT_LIMIT_SMALL = 13'h0100;
	localparam logic [12:0] PROT_LIMIT_HALF = 13'h0800;
	localparam logic [12:0] PROT_LIMIT_ALL = 13'h1000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pfs_bus_t;

	typedef struct packed {
		logic rd_en;
		logic erase;
		logic prog;
		logic [12:0] addr;
		logic [13:0] data;
	} pfs_flash_cmd_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RD_WAIT = 3'b001,
		S_RD_FETCH = 3'b010,
		S_RD_LOAD = 3'b011,
		S_WR_SETUP = 3'b100,
		S_ERASE = 3'b101,
		S_COMMIT = 3'b110
	} pfs_state_t;

	// Locked segment test for a word address
	function automatic logic pfs_is_protected(input logic [12:0] a, input logic [1:0] wp);
		logic res;
		res = 1'b0;
		case (wp)
			2'h2: res = (a < PROT_LIMIT_SMALL);
			2'h1: res = (a < PROT_LIMIT_HALF);
			2'h0: res = (a < PROT_LIMIT_ALL);
			default: res = 1'b0;
		endcase
		return res;
	endfunction

endpackage

/* pfs_unlock.sv */
// Unlock key sequencer: arms after the two keys, any other write disarms
`timescale 1ns/1ps
module pfs_unlock (
	input wire logic clk,
	input wire logic rst_b,
	input wire pfs_pkg::pfs_bus_t bus,
	output logic armed
);

	typedef struct packed {
		logic [1:0] stage;
	} pfs_unlock_st_t;

	pfs_unlock_st_t st;
	pfs_unlock_st_t next_st;

	// Track the key order; any foreign write restarts it
	always_comb begin
		next_st = st;
		if (bus.wr) begin
			if (bus.addr == pfs_pkg::REG_UNLOCK && bus.wdata == pfs_pkg::UNLOCK_KEY_FIRST) begin
				next_st.stage = 2'h1;
			end else if (bus.addr == pfs_pkg::REG_UNLOCK && st.stage == 2'h1
					&& bus.wdata == pfs_pkg::UNLOCK_KEY_SECOND) begin
				next_st.stage = 2'h2;
			end else begin
				next_st.stage = 2'h0;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign armed = (st.stage == 2'h2);

endmodule

/* pfs_word_buf.sv */
// Eight-word staging buffer for one program block
`timescale 1ns/1ps
module pfs_word_buf (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [2:0] load_idx,
	input wire logic [13:0] load_data,
	input wire logic [2:0] rd_idx,
	output logic [13:0] rd_data
);

	typedef struct packed {
		logic [7:0][13:0] words;
	} pfs_buf_st_t;

	pfs_buf_st_t st;
	pfs_buf_st_t next_st;
	logic [7:0][13:0] word_next;

	// One write port per entry
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_entry
			assign word_next[i] = (load && load_idx == 3'(i)) ? load_data : st.words[i];
		end
	endgenerate

	// Next buffer contents
	always_comb begin
		next_st = st;
		next_st.words = word_next;
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.words[rd_idx];

endmodule

/* pfs_flash_ctrl.sv */
// Program flash self-access controller: word reads and eight-word block writes
//
// Notes on behaviour
// - Read with program select steals the second cycle; that instruction is skipped.
// - Fetched word shows in data registers next cycle and holds until changed.
// - Write bit with program select outside the write flow clears at once.
// - Writes only land in segments the protect field leaves open.
// - Blocks are eight sequential words starting at low bits 000.
// - Each block write is a sixteen-word erase then eight-word write, aligned.
// - Write at low bits 111 erases sixteen words then commits the buffer.
// - Two setup cycles follow the write bit; software fills them with no-ops.
// - First seven word loads only fill the buffer, with no stall.
// - Execution halts during erase and commit; clocks keep running.
// - Execution resumes at the third instruction after the write-setting one.
// - Write bit refused without write enable; later clearing does not abort.
// - Read and write bits are set by software, cleared only by hardware.
// - No write starts unless both keys and the write bit come in order.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module pfs_flash_ctrl #(
	parameter int unsigned ERASE_CYCLES = pfs_pkg::ERASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire pfs_pkg::pfs_bus_t bus,
	output logic [7:0] rdata,
	output pfs_pkg::pfs_flash_cmd_t flash_cmd,
	input wire logic [13:0] flash_rdata,
	output logic cpu_stall,
	output logic fetch_steal
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		pfs_pkg::pfs_state_t state;
		logic [15:0] cnt;
		logic [7:0] addr_lo;
		logic [4:0] addr_hi;
		logic [7:0] dat_lo;
		logic [5:0] dat_hi;
		logic sel;
		logic wen;
		logic wr;
		logic rd;
		logic [1:0] wp;
		logic [12:0] wa;
		logic [7:0] rdata;
		pfs_pkg::pfs_flash_cmd_t fcmd;
	} pfs_ctrl_st_t;

	pfs_ctrl_st_t st;
	pfs_ctrl_st_t next_st;

	logic armed;
	logic [12:0] cur_addr;
	logic [13:0] buf_word;
	logic ctl_write;
	logic wr_request;
	logic rd_request;
	logic wr_accept;
	logic wr_locked;
	logic erase_done;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	pfs_unlock u_unlock (
		.clk(clk),
		.rst_b(rst_b),
		.bus(bus),
		.armed(armed)
	);

	pfs_word_buf u_buf (
		.clk(clk),
		.rst_b(rst_b),
		.load(wr_accept),
		.load_idx(st.addr_lo[2:0]),
		.load_data({st.dat_hi, st.dat_lo}),
		.rd_idx(st.cnt[2:0]),
		.rd_data(buf_word)
	);

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	// A control write with a set-only bit high is a request
	assign cur_addr = {st.addr_hi, st.addr_lo};
	assign ctl_write = bus.wr && bus.addr == pfs_pkg::REG_ACCESS_CONTROL;
	assign wr_request = ctl_write && bus.wdata[pfs_pkg::CTL_WR_BIT];
	assign rd_request = ctl_write && bus.wdata[pfs_pkg::CTL_RD_BIT] && !wr_request;
	assign wr_locked = pfs_pkg::pfs_is_protected(cur_addr, st.wp);
	// Only an idle, enabled, unlocked program write to an open segment is taken
	assign wr_accept = wr_request && st.state == pfs_pkg::S_IDLE && armed
		&& bus.wdata[pfs_pkg::CTL_SELECT_BIT] && bus.wdata[pfs_pkg::CTL_WEN_BIT]
		&& !wr_locked;
	assign erase_done = (32'(st.cnt) + 32'h1 >= ERASE_CYCLES);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.fcmd = '0;

		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				pfs_pkg::REG_ADDR_LOW: next_st.addr_lo = bus.wdata;
				pfs_pkg::REG_ADDR_HIGH: next_st.addr_hi = bus.wdata[4:0];
				pfs_pkg::REG_DATA_LOW: next_st.dat_lo = bus.wdata;
				pfs_pkg::REG_DATA_HIGH: next_st.dat_hi = bus.wdata[5:0];
				pfs_pkg::REG_PROTECT_CFG: next_st.wp = bus.wdata[1:0];
				pfs_pkg::REG_ACCESS_CONTROL: begin
					next_st.sel = bus.wdata[pfs_pkg::CTL_SELECT_BIT];
					// Write enable may drop mid-write without effect
					next_st.wen = bus.wdata[pfs_pkg::CTL_WEN_BIT];
				end
				default: begin
				end
			endcase
		end

		// Register reads answer one cycle later
		if (bus.rd) begin
			case (bus.addr)
				pfs_pkg::REG_ADDR_LOW: next_st.rdata = st.addr_lo;
				pfs_pkg::REG_ADDR_HIGH: next_st.rdata = {3'h0, st.addr_hi};
				pfs_pkg::REG_DATA_LOW: next_st.rdata = st.dat_lo;
				pfs_pkg::REG_DATA_HIGH: next_st.rdata = {2'h0, st.dat_hi};
				pfs_pkg::REG_ACCESS_CONTROL: next_st.rdata = {st.sel, 4'h0, st.wen, st.wr, st.rd};
				pfs_pkg::REG_PROTECT_CFG: next_st.rdata = {6'h00, st.wp};
				default: next_st.rdata = pfs_pkg::BYTE_RESET;
			endcase
		end

		// Sequencer
		case (st.state)
			pfs_pkg::S_IDLE: begin
				if (wr_accept) begin
					// Software can only set the write bit
					next_st.wr = 1'b1;
					next_st.wa = cur_addr;
					next_st.cnt = 16'h0000;
					next_st.state = pfs_pkg::S_WR_SETUP;
				end else if (rd_request && bus.wdata[pfs_pkg::CTL_SELECT_BIT]) begin
					next_st.rd = 1'b1;
					next_st.state = pfs_pkg::S_RD_WAIT;
				end
			end
			pfs_pkg::S_RD_WAIT: begin
				// Fetch lands in the second cycle after the request
				next_st.fcmd.rd_en = 1'b1;
				next_st.fcmd.addr = cur_addr;
				next_st.state = pfs_pkg::S_RD_FETCH;
			end
			pfs_pkg::S_RD_FETCH: begin
				next_st.state = pfs_pkg::S_RD_LOAD;
			end
			pfs_pkg::S_RD_LOAD: begin
				// Word is held until another read or a user write
				next_st.dat_lo = flash_rdata[7:0];
				next_st.dat_hi = flash_rdata[13:8];
				next_st.rd = 1'b0;
				next_st.state = pfs_pkg::S_IDLE;
			end
			pfs_pkg::S_WR_SETUP: begin
				next_st.cnt = st.cnt + 16'h0001;
				if (st.cnt == pfs_pkg::SETUP_LAST) begin
					next_st.cnt = 16'h0000;
					if (st.wa[2:0] == pfs_pkg::BLOCK_LAST_WORD) begin
						// Last word: erase the aligned sixteen-word row
						next_st.fcmd.erase = 1'b1;
						next_st.fcmd.addr = {st.wa[12:4], 4'h0};
						next_st.state = pfs_pkg::S_ERASE;
					end else begin
						// Other words only fill the buffer
						next_st.wr = 1'b0;
						next_st.state = pfs_pkg::S_IDLE;
					end
				end
			end
			pfs_pkg::S_ERASE: begin
				next_st.cnt = st.cnt + 16'h0001;
				if (erase_done) begin
					next_st.cnt = 16'h0000;
					next_st.state = pfs_pkg::S_COMMIT;
				end
			end
			pfs_pkg::S_COMMIT: begin
				// One buffer word per cycle, inside the block only
				next_st.fcmd.prog = 1'b1;
				next_st.fcmd.addr = {st.wa[12:3], st.cnt[2:0]};
				next_st.fcmd.data = buf_word;
				next_st.cnt = st.cnt + 16'h0001;
				if (st.cnt[2:0] == pfs_pkg::BLOCK_LAST_WORD) begin
					next_st.cnt = 16'h0000;
					next_st.wr = 1'b0;
					next_st.state = pfs_pkg::S_IDLE;
				end
			end
			default: begin
				next_st.state = pfs_pkg::S_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.wp <= pfs_pkg::PROTECT_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign rdata = st.rdata;
	assign flash_cmd = st.fcmd;
	// Halt only while erasing or committing
	assign cpu_stall = (st.state == pfs_pkg::S_ERASE || st.state == pfs_pkg::S_COMMIT);
	assign fetch_steal = (st.state == pfs_pkg::S_RD_FETCH);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	chk_read_steal: assert property (
		(st.state == pfs_pkg::S_IDLE && rd_request && bus.wdata[pfs_pkg::CTL_SELECT_BIT]
			&& !wr_accept) |-> ##2 (fetch_steal && flash_cmd.rd_en && !cpu_stall)
	) else $error("read fetch not in second cycle");

	chk_read_data: assert property (
		(st.state == pfs_pkg::S_RD_LOAD) |=>
			({st.dat_hi, st.dat_lo} == $past(flash_rdata) && !st.rd)
	) else $error("fetched word not presented");

	chk_wr_refused: assert property (
		(st.state == pfs_pkg::S_IDLE && wr_request && !bus.wdata[pfs_pkg::CTL_WEN_BIT])
			|=> (!st.wr && st.state != pfs_pkg::S_WR_SETUP)
	) else $error("write bit set without enable");

	chk_unlock_order: assert property (
		$rose(st.wr) |-> ($past(armed) && $past(wr_request))
	) else $error("write started without unlock");

	chk_prog_open: assert property (
		(flash_cmd.prog || flash_cmd.erase) |-> !pfs_pkg::pfs_is_protected(st.wa, st.wp)
			|| $changed(st.wp)
	) else $error("write into protected segment");

	chk_locked_quiet: assert property (
		(st.state == pfs_pkg::S_IDLE && wr_request && wr_locked) |=> (!st.wr && !cpu_stall)
	) else $error("protected request not dropped");

	chk_setup_len: assert property (
		$rose(st.wr) |-> (!cpu_stall && st.wr) [*2] ##1 (cpu_stall || !st.wr)
	) else $error("setup is not two cycles");

	chk_load_nostall: assert property (
		($rose(st.wr) && st.wa[2:0] != pfs_pkg::BLOCK_LAST_WORD) |-> ##2 !st.wr && !cpu_stall
	) else $error("buffer load stalled");

	chk_erase_row: assert property (
		flash_cmd.erase |-> (flash_cmd.addr[3:0] == 4'h0 && cpu_stall
			&& st.wa[2:0] == pfs_pkg::BLOCK_LAST_WORD)
	) else $error("erase not row aligned");

	chk_commit_block: assert property (
		flash_cmd.prog |-> (flash_cmd.addr[12:3] == st.wa[12:3])
	) else $error("commit left its block");

	chk_commit_count: assert property (
		(st.state == pfs_pkg::S_ERASE && erase_done)
			|=> ##1 flash_cmd.prog [*8] ##1 !flash_cmd.prog
	) else $error("commit is not eight words");

	chk_resume: assert property (
		$fell(cpu_stall) |-> (!st.wr && st.state == pfs_pkg::S_IDLE && flash_cmd.prog)
	) else $error("resume without finished commit");

	chk_rw_set_only: assert property (
		$fell(st.wr) |-> $past(st.state == pfs_pkg::S_WR_SETUP || st.state == pfs_pkg::S_COMMIT)
	) else $error("write bit cleared outside completion");

	chk_pgm_wr_clear: assert property (
		(st.state == pfs_pkg::S_IDLE && wr_request && !armed) |=> !st.wr
	) else $error("stray write bit not cleared");

	// Bit clearing, stall window and block edges
	chk_rd_bit_clear: assert property (
		$rose(st.rd) |-> st.rd [*3] ##1 !st.rd
	) else $error("read bit not cleared after fetch");

	chk_stall_start: assert property (
		$rose(cpu_stall) |-> (flash_cmd.erase && !fetch_steal)
	) else $error("stall began without erase");

	chk_erase_span: assert property (
		(st.state == pfs_pkg::S_ERASE) |-> (32'(st.cnt) < ERASE_CYCLES && cpu_stall)
	) else $error("erase ran past its length");

	chk_block_start: assert property (
		(st.state == pfs_pkg::S_ERASE && erase_done)
			|-> ##2 (flash_cmd.prog && flash_cmd.addr[2:0] == 3'h0)
	) else $error("commit not starting at block edge");

	chk_busy_read: assert property (
		(st.state == pfs_pkg::S_ERASE && rd_request) |-> ##2 !flash_cmd.rd_en
	) else $error("read served during erase");

	chk_select_zero: assert property (
		(st.state == pfs_pkg::S_IDLE && wr_request && !bus.wdata[pfs_pkg::CTL_SELECT_BIT])
			|=> (!st.wr && !cpu_stall)
	) else $error("data memory write request acted on");

	chk_wen_drop: assert property (
		(st.state == pfs_pkg::S_ERASE && ctl_write && !bus.wdata[pfs_pkg::CTL_WEN_BIT])
			|=> (st.wr && cpu_stall)
	) else $error("enable drop aborted the write");

	chk_data_hold: assert property (
		(!bus.wr && st.state != pfs_pkg::S_RD_LOAD) |=> $stable({st.dat_hi, st.dat_lo})
	) else $error("data registers changed on their own");

	chk_steal_once: assert property (
		fetch_steal |=> !fetch_steal
	) else $error("steal longer than one cycle");

	chk_commit_end: assert property (
		(st.state == pfs_pkg::S_COMMIT && st.cnt[2:0] == pfs_pkg::BLOCK_LAST_WORD)
			|=> (!cpu_stall && !st.wr && st.state == pfs_pkg::S_IDLE)
	) else $error("execution not resumed after commit");

endmodule

/* pfs_testbench.sv */
// Self-checking testbench of the program flash self-access controller
`timescale 1ns/1ps
module testbench;
	localparam int E = 8;
	logic clk;
	logic rst_b;
	pfs_pkg::pfs_bus_t bus;
	logic [7:0] rdata;
	pfs_pkg::pfs_flash_cmd_t fc;
	logic [13:0] flash_rdata;
	logic cpu_stall;
	logic fetch_steal;
	logic [13:0] mem [0:8191];
	logic [13:0] w [0:7];
	logic [12:0] pa [0:7];
	logic [13:0] pd [0:7];
	logic [12:0] er_addr;
	int n_fail, tests_run, cyc, t_ctl, t_er, t_pg, n_er, n_pg, n_rd, n_st, n_stall;

	pfs_flash_ctrl #(.ERASE_CYCLES(E)) pfs_flash_ctrl_i (.clk(clk), .rst_b(rst_b), .bus(bus),
		.rdata(rdata), .flash_cmd(fc), .flash_rdata(flash_rdata), .cpu_stall(cpu_stall),
		.fetch_steal(fetch_steal));

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Flash array model; the data line scrambles when no read is answered
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (bus.wr && bus.addr == pfs_pkg::REG_ACCESS_CONTROL && bus.wdata[pfs_pkg::CTL_WR_BIT])
			t_ctl <= cyc;
		flash_rdata <= fc.rd_en ? mem[fc.addr] : ~flash_rdata;
		if (fc.rd_en) n_rd <= n_rd + 1;
		if (fc.rd_en && fetch_steal) n_st <= n_st + 1;
		if (cpu_stall) n_stall <= n_stall + 1;
		if (fc.erase) begin
			t_er <= cyc;
			er_addr <= fc.addr;
			n_er <= n_er + 1;
			for (int j = 0; j < 16; j++) mem[{fc.addr[12:4], j[3:0]}] <= 14'h3fff;
		end
		if (fc.prog) begin
			if (n_pg == 0) t_pg <= cyc;
			pa[n_pg[2:0]] <= fc.addr;
			pd[n_pg[2:0]] <= fc.data;
			mem[fc.addr] <= fc.data;
			n_pg <= n_pg + 1;
		end
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One strobe cycle, then one idle cycle; read data sampled in the answer cycle
	task automatic op(input logic is_wr, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		bus <= {a, d, is_wr, ~is_wr};
		@(posedge clk);
		bus <= '0;
		#1 q = rdata;
		@(posedge clk);
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		op(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
		logic [7:0] q;
		op(1'b0, a, 8'h00, q);
		check({8'h00, q}, {8'h00, exp}, what);
	endtask

	task automatic set_addr(input logic [12:0] a);
		wr(pfs_pkg::REG_ADDR_LOW, a[7:0]);
		wr(pfs_pkg::REG_ADDR_HIGH, {3'h0, a[12:8]});
	endtask

	// Address, data, two keys, then the control write
	task automatic load(input logic [12:0] a, input logic [13:0] d, input logic [7:0] ctl,
		input logic [7:0] k1);
		set_addr(a);
		wr(pfs_pkg::REG_DATA_LOW, d[7:0]);
		wr(pfs_pkg::REG_DATA_HIGH, {2'h0, d[13:8]});
		wr(pfs_pkg::REG_UNLOCK, k1);
		wr(pfs_pkg::REG_UNLOCK, pfs_pkg::UNLOCK_KEY_SECOND);
		wr(pfs_pkg::REG_ACCESS_CONTROL, ctl);
	endtask

	task automatic pread(input logic [12:0] a, input logic [13:0] exp);
		int r0;
		int s0;
		set_addr(a);
		r0 = n_rd;
		s0 = n_st;
		wr(pfs_pkg::REG_ACCESS_CONTROL, 8'h81);
		repeat (3) @(posedge clk);
		check(16'(n_rd - r0), 16'h1, "array read count");
		check(16'(n_st - s0), 16'h1, "steal with read");
		rdc(pfs_pkg::REG_DATA_LOW, exp[7:0], "word low");
		rdc(pfs_pkg::REG_DATA_HIGH, {2'h0, exp[13:8]}, "word high");
	endtask

	// Refused write: no erase, no stall, write bit never seen
	task automatic refused(input logic [12:0] a, input logic [7:0] ctl, input logic [7:0] k1);
		int e0;
		int s0;
		e0 = n_er;
		s0 = n_stall;
		load(a, 14'h1234, ctl, k1);
		repeat (E + 12) @(posedge clk);
		rdc(pfs_pkg::REG_ACCESS_CONTROL, ctl & 8'hfc, "refused control");
		check(16'(n_er - e0), 16'h0, "refused erase");
		check(16'(n_stall - s0), 16'h0, "refused stall");
	endtask

	// Watchdog against a hang
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] m;
		logic [12:0] base;
		int i;
		int e0;
		int s0;
		int h;
		void'($urandom(32'h3839));
		rst_b = 1'b0;
		bus = '0;
		flash_rdata = 14'h0000;
		{n_fail, tests_run, cyc, t_ctl, t_er, t_pg, n_er, n_pg, n_rd, n_st, n_stall} = '0;
		er_addr = 13'h0000;
		for (i = 0; i < 8192; i++) mem[i] = 14'($urandom);
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 8; i++) rdc(3'(i), (i == 6) ? 8'h03 : 8'h00, "reset value");
		for (i = 0; i < 4; i++) begin
			v = 8'($urandom);
			m = (i == 1) ? 8'h1f : ((i == 3) ? 8'h3f : 8'hff);
			wr(3'(i), v);
			rdc(3'(i), v & m, "user write");
		end
		pread(13'h1fff, mem[13'h1fff]);
		for (i = 0; i < 3; i++) begin
			base = 13'($urandom);
			pread(base, mem[base]);
		end
		refused(13'h01ff, 8'h82, pfs_pkg::UNLOCK_KEY_FIRST);
		refused(13'h01ff, 8'h86, pfs_pkg::UNLOCK_KEY_SECOND);
		refused(13'h01ff, 8'h86, 8'h00);
		refused(13'h01ff, 8'h06, pfs_pkg::UNLOCK_KEY_FIRST);
		wr(pfs_pkg::REG_PROTECT_CFG, 8'h02);
		rdc(pfs_pkg::REG_PROTECT_CFG, 8'h02, "protect field");
		refused(13'h00ff, 8'h86, pfs_pkg::UNLOCK_KEY_FIRST);
		base = 13'h0100 + (13'($urandom_range(0, 13'h0eff)) & 13'h1ff0);
		// Lower block, then upper block with some words kept by read-back
		for (h = 0; h < 2; h++) begin
			e0 = n_er;
			s0 = n_stall;
			n_pg = 0;
			for (i = 0; i < 8; i++) begin
				w[i] = 14'($urandom);
				if (h == 1 && w[i][0]) begin
					pread(base + 13'(8 + i), 14'h3fff);
					w[i] = 14'h3fff;
				end
				load(base + 13'(8 * h + i), w[i], 8'h86, pfs_pkg::UNLOCK_KEY_FIRST);
				if (i < 7) begin
					@(posedge clk);
					rdc(pfs_pkg::REG_ACCESS_CONTROL, 8'h84, "buffer load done");
					check(16'(n_stall - s0), 16'h0, "buffer load stall");
				end else if (h == 1) begin
					// Drop enable and ask for a read in mid-erase: both are ignored
					repeat (2) @(posedge clk);
					wr(pfs_pkg::REG_ACCESS_CONTROL, 8'h81);
				end
			end
			for (i = 0; i < 200 && n_pg < 8; i++) @(posedge clk);
			if (n_pg < 8) begin
				n_fail++;
				$display("[ERR] %0t commit never finished", $time);
				end_of_test();
			end
			repeat (2) @(posedge clk);
			check(16'(n_er - e0), 16'h1, "erase count");
			check({3'h0, er_addr}, {3'h0, base[12:4], 4'h0}, "erase row");
			check(16'(t_er - t_ctl), 16'h3, "setup cycles");
			check(16'(t_pg - t_er), 16'(E + 1), "erase length");
			check(16'(n_stall - s0), 16'(E + 8), "stall length");
			for (i = 0; i < 8; i++) begin
				check({3'h0, pa[i]}, {3'h0, base + 13'(8 * h + i)}, "commit address");
				check({2'h0, pd[i]}, {2'h0, w[i]}, "commit data");
			end
			rdc(pfs_pkg::REG_ACCESS_CONTROL, (h == 1) ? 8'h80 : 8'h84, "write bit cleared");
			for (i = 0; i < 8; i++) begin
				pread(base + 13'(8 * h + i), w[i]);
				pread(base + 13'(8 - 8 * h + i), 14'h3fff);
			end
		end
		end_of_test();
	end
endmodule
